// *** dv/apc_host_model.sv ***
// Host model that loads the configuration pair and frames it with select.
`timescale 1ns/1ps
`default_nettype none
module apc_host_model (
   input wire logic clk_i,
   output logic [15:0] data_o,
   output logic ld_p_o,
   output logic ld_s_o,
   output logic ss_n_o
);
   initial
   begin
      data_o = 16'h0000;
      ld_p_o = 1'b0;
      ld_s_o = 1'b0;
      ss_n_o = 1'b1;
   end
   // The word is inverted after its strobe so stale data is never reused.
   task automatic put(input logic sec, input logic [15:0] d);
      @(negedge clk_i);
      data_o = d;
      ld_p_o = !sec;
      ld_s_o = sec;
      @(negedge clk_i);
      ld_p_o = 1'b0;
      ld_s_o = 1'b0;
      data_o = ~d;
   endtask
   task automatic send(input logic [1:0] m, input logic [15:0] p,
      input logic [15:0] s);
      @(negedge clk_i);
      ss_n_o = 1'b0;
      if (m[0])
         put(1'b0, p);
      if (m[1])
         put(1'b1, s);
      @(negedge clk_i);
      ss_n_o = 1'b1;
      repeat (3) @(negedge clk_i);
   endtask
endmodule
`default_nettype wire

// *** dv/apc_top_monitor.sv ***
// Port checker for the audio path configuration decoder.
`timescale 1ns/1ps
`default_nettype none
module apc_top_monitor #(
   parameter int CFG_W = 16
) (
   input wire logic MCLK_I,
   input wire logic RESETN_I,
   input wire logic [CFG_W-1:0] WR_DATA_I,
   input wire logic LOAD_PRIMARY_I,
   input wire logic LOAD_SECONDARY_I,
   input wire logic SS_N_I,
   input wire logic CHIP_POWER_ON_I,
   input wire logic [CFG_W-1:0] PRIMARY_RD_O,
   input wire logic [CFG_W-1:0] SECONDARY_RD_O,
   input wire logic UPDATE_PENDING_O,
   input wire apc_pkg::apc_ctrl_t CTRL_O
);
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RESETN_I);
   sequence ss_seen;
      !SS_N_I ##1 !SS_N_I ##1 (SS_N_I && UPDATE_PENDING_O);
   endsequence
   sequence ss_quiet;
      (SS_N_I && !LOAD_SECONDARY_I) [*3];
   endsequence
   a_pend_set:
      assert property (LOAD_SECONDARY_I |=> UPDATE_PENDING_O)
      else $error("pending not set");
   a_commit_clear:
      assert property (ss_seen ##0 ss_quiet |=> !UPDATE_PENDING_O)
      else $error("commit missed");
   a_pend_hold:
      assert property (UPDATE_PENDING_O && !SS_N_I |=> UPDATE_PENDING_O)
      else $error("pending lost early");
   a_prim_rback:
      assert property (LOAD_PRIMARY_I |=> ##1
         PRIMARY_RD_O == $past(WR_DATA_I, 2))
      else $error("primary readback wrong");
   a_sec_rback:
      assert property (LOAD_SECONDARY_I |=> ##1
         SECONDARY_RD_O == $past(WR_DATA_I, 2))
      else $error("secondary readback wrong");
   a_rback_stable:
      assert property (!LOAD_PRIMARY_I [*2] |=> $stable(PRIMARY_RD_O))
      else $error("primary readback moved");
   a_power_hold:
      assert property (!CHIP_POWER_ON_I |=> $stable(CTRL_O))
      else $error("controls moved while off");
   a_ctrl_hold:
      assert property (CHIP_POWER_ON_I && $past(CHIP_POWER_ON_I) &&
         $past(RESETN_I) && !UPDATE_PENDING_O &&
         !$past(UPDATE_PENDING_O) |=> $stable(CTRL_O))
      else $error("controls moved without commit");
endmodule
bind apc_top apc_top_monitor #(.CFG_W(CFG_W)) apc_top_monitor_i (
   .MCLK_I, .RESETN_I, .WR_DATA_I, .LOAD_PRIMARY_I, .LOAD_SECONDARY_I,
   .SS_N_I, .CHIP_POWER_ON_I, .PRIMARY_RD_O, .SECONDARY_RD_O,
   .UPDATE_PENDING_O, .CTRL_O
);
`default_nettype wire

// *** dv/audio_path_config_decode_bench.sv ***
// Self-checking bench for the audio path configuration decoder.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
   begin \
      comparisons++; \
      if ((a) !== (e)) \
      begin \
         mismatches++; \
         $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); \
      end \
   end
module audio_path_config_decode_bench;
   logic clk, rst_n, pwr, lp, ls, ss_n, pend;
   logic [15:0] wd, prd, srd, hp, hs;
   logic [31:0] x;
   apc_pkg::apc_ctrl_t ctrl, exp_c, act, cur;
   apc_pkg::apc_ctrl_t notes[$];
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   apc_top apc_top_i (.MCLK_I(clk), .RESETN_I(rst_n), .WR_DATA_I(wd),
      .LOAD_PRIMARY_I(lp), .LOAD_SECONDARY_I(ls), .SS_N_I(ss_n),
      .CHIP_POWER_ON_I(pwr), .PRIMARY_RD_O(prd), .SECONDARY_RD_O(srd),
      .UPDATE_PENDING_O(pend), .CTRL_O(ctrl));
   apc_host_model apc_host_model_i (.clk_i(clk), .data_o(wd), .ld_p_o(lp),
      .ld_s_o(ls), .ss_n_o(ss_n));
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
   endfunction
   function automatic apc_pkg::apc_ctrl_t dec(input logic [15:0] p,
      input logic [15:0] s);
      dec = apc_pkg::apc_ctrl_t'({s[10:7], s[4], s[1],
         s[3:2], s[6:5], s[6:5] != 2'h3, s[0],
         p[9], s[15:14], p[0], s[13:11],
         p[4:3], p[2:1]});
   endfunction
   task automatic summarize();
      $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic go(input logic [1:0] m, input logic [15:0] p,
      input logic [15:0] s);
      if (m[0])
         hp = p;
      if (m[1])
      begin
         hs = s;
         act = dec(hp, s);
         if (pwr)
            cur = act;
         notes.push_back(cur);
      end
      apc_host_model_i.send(m, p, s);
      @(negedge clk);
      `CHK(prd, hp)
      `CHK(srd, hs)
      `CHK(ctrl, cur)
   endtask
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         mismatches++;
         summarize();
      end
   end
   always @(negedge pend iff rst_n)
   begin
      repeat (2) @(negedge clk);
      exp_c = notes.pop_front();
      `CHK(ctrl, exp_c)
   end
   initial
   begin
      rst_n = 1'b0;
      pwr = 1'b0;
      x = 32'h46D3;
      hp = 16'h0001;
      hs = 16'h01E3;
      act = dec(hp, hs);
      cur = '0;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      `CHK({ctrl, prd, srd, pend}, {cur, hp, hs, 1'b0})
      pwr = 1'b1;
      repeat (2) @(negedge clk);
      cur = act;
      `CHK(ctrl, cur)
      go(2'h3, 16'h440B, 16'h01E3);
      go(2'h2, 16'h0000, 16'h00C5);
      go(2'h1, 16'h2421, 16'h0000);
      go(2'h2, 16'h0000, 16'h0148);
      go(2'h3, 16'h2422, 16'h59D1);
      pwr = 1'b0;
      x = xs(x);
      go(2'h3, x[15:0], x[31:16]);
      pwr = 1'b1;
      repeat (2) @(negedge clk);
      cur = act;
      `CHK(ctrl, cur)
      repeat (4)
      begin
         x = xs(x);
         go(2'h3, x[15:0], x[31:16]);
      end
      summarize();
   end
endmodule
`default_nettype wire

// *** logic/apc_hold_reg.sv ***
// Loadable register with a constant reset value.
`timescale 1ns/1ps
`default_nettype none
module apc_hold_reg #(
   parameter int W = 16,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic load_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] val_q;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         val_q <= RST;
      end
      else if (load_i)
      begin
         val_q <= d_i;
      end
   end

   assign q_o = val_q;

endmodule
`default_nettype wire

// *** logic/apc_top.sv ***
// Configuration register pair and decoder for the audio routing controls.
`timescale 1ns/1ps
`default_nettype none
`include "apc_regs.svh"
module apc_top #(
   parameter int CFG_W = `APC_CFG_W
) (
   input wire logic MCLK_I,
   input wire logic RESETN_I,
   input wire logic [CFG_W-1:0] WR_DATA_I,
   input wire logic LOAD_PRIMARY_I,
   input wire logic LOAD_SECONDARY_I,
   input wire logic SS_N_I,
   input wire logic CHIP_POWER_ON_I,
   output logic [CFG_W-1:0] PRIMARY_RD_O,
   output logic [CFG_W-1:0] SECONDARY_RD_O,
   output logic UPDATE_PENDING_O,
   output var apc_pkg::apc_ctrl_t CTRL_O
);

   // Slave select arrives from a pin, so it is synchronised first.
   logic ss_meta_q;
   logic ss_sync_q;
   logic ss_prev_q;
   logic ss_rise;

   logic [CFG_W-1:0] hold_primary;
   logic [CFG_W-1:0] staged_secondary;
   logic [CFG_W-1:0] act_primary;
   logic [CFG_W-1:0] act_secondary;
   logic pend_q;
   logic commit;

   apc_pkg::apc_ctrl_t decoded;
   apc_pkg::apc_ctrl_t ctrl_q;

   always_ff @(posedge MCLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         ss_meta_q <= 1'h1;
         ss_sync_q <= 1'h1;
      end
      else
      begin
         ss_meta_q <= SS_N_I;
         ss_sync_q <= ss_meta_q;
      end
   end

   always_ff @(posedge MCLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         ss_prev_q <= 1'h1;
      end
      else
      begin
         ss_prev_q <= ss_sync_q;
      end
   end

   assign ss_rise = ss_sync_q & ~ss_prev_q;

   // A primary write only fills the holding register; apart from the PRIMARY_RD_O
   // readback, nothing downstream sees it until the next secondary load is committed.
   apc_hold_reg #(
      .W(CFG_W),
      .RST(CFG_W'(`APC_PRIMARY_RST))
   ) u_hold_primary (
      .clk_i(MCLK_I),
      .rst_n_i(RESETN_I),
      .load_i(LOAD_PRIMARY_I), // [R16]
      .d_i(WR_DATA_I),
      .q_o(hold_primary)
   );

   apc_hold_reg #(
      .W(CFG_W),
      .RST(CFG_W'(`APC_SECONDARY_RST))
   ) u_stage_secondary (
      .clk_i(MCLK_I),
      .rst_n_i(RESETN_I),
      .load_i(LOAD_SECONDARY_I),
      .d_i(WR_DATA_I),
      .q_o(staged_secondary)
   );

   // The commit happens when the command frame ends, that is on the
   // synchronised rising edge of slave select after a secondary load.
   assign commit = pend_q & ss_rise; // [R16]

   always_ff @(posedge MCLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         pend_q <= 1'h0;
      end
      else if (LOAD_SECONDARY_I)
      begin
         // A load in the commit cycle keeps the flag set, so it is not lost.
         pend_q <= 1'h1;
      end
      else if (commit)
      begin
         pend_q <= 1'h0;
      end
   end

   // Both active registers move in the same cycle, so the primary field
   // never lands on its own.
   apc_hold_reg #(
      .W(CFG_W),
      .RST(CFG_W'(`APC_PRIMARY_RST))
   ) u_act_primary (
      .clk_i(MCLK_I),
      .rst_n_i(RESETN_I),
      .load_i(commit), // [R16]
      .d_i(hold_primary),
      .q_o(act_primary)
   );

   apc_hold_reg #(
      .W(CFG_W),
      .RST(CFG_W'(`APC_SECONDARY_RST))
   ) u_act_secondary (
      .clk_i(MCLK_I),
      .rst_n_i(RESETN_I),
      .load_i(commit), // [R16]
      .d_i(staged_secondary),
      .q_o(act_secondary)
   );

   // Field decode of the committed pair.
   always_comb
   begin
      decoded = '0;
      decoded.first_summer_src =
         act_secondary[`APC_S_S1SRC_LSB +: 2]; // [R1]
      decoded.first_summer_mode = apc_pkg::apc_sum_mode_t'(
         act_secondary[`APC_S_SUM1_LSB +: 2]); // [R2]
      decoded.filter_input_sel =
         act_secondary[`APC_S_FILT_SEL]; // [R3]
      decoded.lowpass_power_off =
         act_secondary[`APC_S_LP_OFF]; // [R4]
      decoded.rate_sel = apc_pkg::apc_rate_t'(
         act_secondary[`APC_S_RATE_LSB +: 2]); // [R5]
      decoded.second_summer_mode = apc_pkg::apc_sum_mode_t'(
         act_secondary[`APC_S_SUM2_LSB +: 2]); // [R6]
      // The store can only be fed from the second summer, so the feed is
      // live exactly when that summer is not powered down.
      decoded.store_feed_en = (decoded.second_summer_mode !=
         apc_pkg::APC_SUM_OFF); // [R7]
      decoded.gain_ctrl_amp_off =
         act_secondary[`APC_S_GAIN_OFF]; // [R8]
      decoded.input_source_sel =
         act_primary[`APC_P_INSRC]; // [R9]
      decoded.attenuator_src_sel = apc_pkg::apc_attn_src_t'(
         act_secondary[`APC_S_ASRC_LSB +: 2]); // [R10]
      decoded.attenuator_power_off =
         act_primary[`APC_P_ATTN_OFF]; // [R11]
      decoded.loudness_attn =
         act_secondary[`APC_S_ATTN_LSB +: 3]; // [R12]
      decoded.output_sel = apc_pkg::apc_out_sel_t'(
         act_primary[`APC_P_OUT_LSB +: 2]); // [R13]
      decoded.driver_mode = apc_pkg::apc_drv_mode_t'(
         act_primary[`APC_P_DRV_LSB +: 2]); // [R14]
   end

   // While the chip is powered off the controls keep their last values;
   // the committed settings appear only once power-on is set. Holding
   // rather than forcing a power-down pattern avoids a burst of mux
   // changes in the analog stages when power returns.
   always_ff @(posedge MCLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         ctrl_q <= '0;
      end
      else if (CHIP_POWER_ON_I) // [R18]
      begin
         ctrl_q <= decoded; // [R19]
      end
   end

   always_ff @(posedge MCLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         PRIMARY_RD_O <= CFG_W'(`APC_PRIMARY_RST);
         SECONDARY_RD_O <= CFG_W'(`APC_SECONDARY_RST);
      end
      else
      begin
         PRIMARY_RD_O <= hold_primary;
         SECONDARY_RD_O <= staged_secondary;
      end
   end

   assign UPDATE_PENDING_O = pend_q;
   assign CTRL_O = ctrl_q;

endmodule
`default_nettype wire

// *** pkg/apc_pkg.sv ***
// Types shared by the audio path configuration decoder.
`default_nettype none
package apc_pkg;

   typedef enum logic [1:0] {
      APC_RATE_8K0 = 2'h0,
      APC_RATE_6K4 = 2'h1,
      APC_RATE_5K3 = 2'h2,
      APC_RATE_RSVD = 2'h3
   } apc_rate_t;

   typedef enum logic [1:0] {
      APC_SUM_BOTH = 2'h0,
      APC_SUM_FIRST_ONLY = 2'h1,
      APC_SUM_SECOND_ONLY = 2'h2,
      APC_SUM_OFF = 2'h3
   } apc_sum_mode_t;

   typedef enum logic [1:0] {
      APC_ASRC_ANA_IN = 2'h0,
      APC_ASRC_SUM2 = 2'h1,
      APC_ASRC_SUM1 = 2'h2,
      APC_ASRC_INPUT = 2'h3
   } apc_attn_src_t;

   typedef enum logic [1:0] {
      APC_OUT_ATTN = 2'h0,
      APC_OUT_ANA_IN = 2'h1,
      APC_OUT_SEL2 = 2'h2,
      APC_OUT_SEL3 = 2'h3
   } apc_out_sel_t;

   typedef enum logic [1:0] {
      APC_DRV_MODE0 = 2'h0,
      APC_DRV_SPK_HIGH = 2'h1,
      APC_DRV_MODE2 = 2'h2,
      APC_DRV_MODE3 = 2'h3
   } apc_drv_mode_t;

   typedef struct packed {
      logic [1:0] first_summer_src;
      apc_sum_mode_t first_summer_mode;
      logic filter_input_sel;
      logic lowpass_power_off;
      apc_rate_t rate_sel;
      apc_sum_mode_t second_summer_mode;
      logic store_feed_en;
      logic gain_ctrl_amp_off;
      logic input_source_sel;
      apc_attn_src_t attenuator_src_sel;
      logic attenuator_power_off;
      logic [2:0] loudness_attn;
      apc_out_sel_t output_sel;
      apc_drv_mode_t driver_mode;
   } apc_ctrl_t;

endpackage
`default_nettype wire

// *** pkg/apc_regs.svh ***
// Offsets, field positions, reset values and rate figures of the block.
// Notes on behaviour
// R1 - Secondary D10:D9 pick first summer input; 00 analog-in.
// R2 - Secondary D8:D7 set first summer mode.
// R3 - Secondary D4 picks filter input: summer or store.
// R4 - Secondary D1 powers low-pass filter off; zero on.
// R5 - Secondary D3:D2 pick filter and sample rate.
// R6 - Secondary D6:D5 set second summer mode.
// R7 - Store record input fed only by second summer.
// R8 - Secondary D0 powers gain amplifier off; zero on.
// R9 - Primary D9 picks input source; zero microphone amplifier.
// R10 - Secondary D15:D14 pick attenuator source.
// R11 - Primary D0 powers attenuator off; zero on.
// R12 - Secondary D13:D11 binary attenuation level, 000 to 111.
// R13 - Primary D4:D3 pick output; 00 attenuator to speaker.
// R14 - Primary D2:D1 set output drivers.
// R15 - Host loads both registers when primary changes; the bench also sends one primary-only frame (go with mask 2'h1).
// R16 - Primary write held; applied with next secondary load.
// R17 - Host writes primary before secondary.
// R18 - Loads accepted powered down; visible after power-on.
// R19 - Decoded controls held static between updates.
`ifndef APC_REGS_SVH
`define APC_REGS_SVH

`define APC_CFG_W 16
`define APC_PRIMARY_RST 16'h0001
`define APC_SECONDARY_RST 16'h01E3

`define APC_P_ATTN_OFF 0
`define APC_P_DRV_LSB 1
`define APC_P_OUT_LSB 3
`define APC_P_INSRC 9

`define APC_S_GAIN_OFF 0
`define APC_S_LP_OFF 1
`define APC_S_RATE_LSB 2
`define APC_S_FILT_SEL 4
`define APC_S_SUM2_LSB 5
`define APC_S_SUM1_LSB 7
`define APC_S_S1SRC_LSB 9
`define APC_S_ATTN_LSB 11
`define APC_S_ASRC_LSB 14

`define APC_RATE_8K0_HZ 8000
`define APC_RATE_6K4_HZ 6400
`define APC_RATE_5K3_HZ 5300

`endif
